// ### design/uspm_if.sv
`timescale 1ns/1ps
`default_nettype none
// wake event bundle between the sleep controller and the pump timer
interface uspm_wake_if;
	logic rx_start;
	logic tx_load;
	logic modem_rise;
	logic core_asleep;
	logic autosleep;
	modport ctrl (output rx_start, output tx_load, output modem_rise, output core_asleep, output autosleep);
	modport pump (input rx_start, input tx_load, input modem_rise, input core_asleep, input autosleep);
endinterface
`default_nettype wire

// ### design/uspm_pkg.sv
package uspm_pkg;
	// reset values
	localparam logic RST_OSC_EN = 1'b1;
	localparam logic RST_PUMP_ON = 1'b1;
	// interrupt source lower nibble for the wake interrupt
	localparam logic [3:0] WAKE_ISR_CODE = 4'h1;
	// clock rate
	localparam int CLK_HZ = 50_000_000;
	// charge-pump idle time before shutdown
	localparam int IDLE_TIME_S = 30;
	localparam longint IDLE_CYCLES = longint'(IDLE_TIME_S) * longint'(CLK_HZ);
	// charge-pump restart time, least time rounds up
	localparam int PUMP_UP_NS = 45_000;
	localparam int PUMP_UP_CYCLES = (PUMP_UP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PUMP_CNT_W = 12;
	localparam int IDLE_CNT_W = 32;
	// core power states
	typedef enum logic [1:0] {
		USPM_AWAKE = 2'b00,
		USPM_ASLEEP = 2'b01,
		USPM_WAKING = 2'b10
	} uspm_state_e;
endpackage

// ### design/uspm_pump_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module uspm_pump_ctrl #(
	parameter longint IDLE_LIMIT = uspm_pkg::IDLE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// events
	uspm_wake_if.pump ev,
	// activity levels
	input wire logic tx_active,
	input wire logic modem_any_high,
	input wire logic modem_change,
	// status
	output logic pump_on,
	output logic pump_ready
);
	import uspm_pkg::*;
	logic pump_on_r, pump_on_nxt;
	logic pump_ready_r, pump_ready_nxt;
	logic [IDLE_CNT_W-1:0] idle_r, idle_nxt;
	logic [PUMP_CNT_W-1:0] up_r, up_nxt;
	logic asleep_d_r, asleep_d_nxt;
	logic wake_ev;
	logic idle_done;
	assign wake_ev = ev.rx_start | ev.tx_load | ev.modem_rise;
	assign idle_done = (idle_r >= IDLE_CNT_W'(IDLE_LIMIT));
	// pump on/off and restart settling
	always_comb begin
		pump_on_nxt = pump_on_r;
		pump_ready_nxt = pump_ready_r;
		idle_nxt = idle_r;
		up_nxt = up_r;
		// idle timer restarts on any line activity
		if (tx_active | modem_any_high | modem_change | wake_ev | !ev.autosleep) begin
			idle_nxt = '0;
		end else if (!idle_done) begin
			idle_nxt = idle_r + IDLE_CNT_W'(1);
		end
		if (!ev.autosleep) begin
			pump_on_nxt = 1'b1;
		end else if (pump_on_r && ev.core_asleep) begin
			pump_on_nxt = 1'b0;
		end else if (pump_on_r && idle_done && !tx_active && !modem_any_high) begin
			pump_on_nxt = 1'b0;
		end else if (!pump_on_r && asleep_d_r && !ev.core_asleep) begin
			// oscillator restart
			// here only the step out of core sleep restarts it; an idle shutdown while awake stays off until a wake event or autosleep low
			pump_on_nxt = 1'b1;
		end else if (!pump_on_r && wake_ev) begin
			pump_on_nxt = 1'b1;
		end
		// a fresh restart gets the full idle time again, else it would drop at once
		if (pump_on_nxt && !pump_on_r) begin
			idle_nxt = '0;
		end
		asleep_d_nxt = ev.core_asleep;
		// drivers usable only after restart delay
		if (!pump_on_nxt) begin
			pump_ready_nxt = 1'b0;
			up_nxt = '0;
		end else if (!pump_ready_r) begin
			if (up_r >= PUMP_CNT_W'(PUMP_UP_CYCLES - 1)) begin
				pump_ready_nxt = 1'b1;
			end else begin
				up_nxt = up_r + PUMP_CNT_W'(1);
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			pump_on_r <= RST_PUMP_ON;
			pump_ready_r <= 1'b1;
			idle_r <= '0;
			up_r <= '0;
			asleep_d_r <= 1'b0;
		end else begin
			pump_on_r <= pump_on_nxt;
			pump_ready_r <= pump_ready_nxt;
			idle_r <= idle_nxt;
			up_r <= up_nxt;
			asleep_d_r <= asleep_d_nxt;
		end
	end
	assign pump_on = pump_on_r;
	assign pump_ready = pump_ready_r;
endmodule
`default_nettype wire

// ### design/uspm_top.sv
// What this block does
// - sleep needs enable, idle, divisor, quiet lines
// - autosleep low keeps pump always running
// - sleep stops oscillator output
// - wake on start bit, tx load, modem
// - wake interrupt code 0x1, cleared by read
// - auto re-sleep; never sleep with pending interrupt
// - cycling continues until sleep enable cleared
// - pump off after 30 s line idle
// - pump off tri-states drivers, receivers stay
// - pump restarts on events, ready 45 us
// - full sleep when asleep and autosleep high
// - full sleep exit on autosleep low or oscillator
// - power-save isolates bus when asleep
// - power-save wakes only on line events
// - power-save re-entered after servicing
// - power-save until enable or select cleared
// - power-save wake interrupt after oscillator ready
`timescale 1ns/1ps
`default_nettype none
module uspm_top #(
	parameter longint IDLE_LIMIT = uspm_pkg::IDLE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// configuration
	input wire logic sleep_enable,
	input wire logic [15:0] baud_divisor,
	input wire logic charge_pump_autosleep,
	input wire logic bus_isolation_select,
	// uart core status
	input wire logic int_pending,
	input wire logic [3:0] modem_status_low,
	input wire logic [3:0] modem_inputs,
	input wire logic rx_in,
	input wire logic tx_active,
	input wire logic osc_stable,
	// host bus events
	input wire logic thr_write,
	input wire logic isr_read,
	input wire logic msr_read,
	// power controls
	output logic osc_enable,
	output logic core_clk_enable,
	output logic osc_out_enable,
	output logic pump_enable,
	output logic driver_oe_n,
	output logic bus_isolate,
	output logic full_sleep,
	// wake interrupt
	output logic wake_int,
	output logic [3:0] wake_isr_code
);
	import uspm_pkg::*;
	uspm_wake_if wif();
	uspm_state_e state_r, state_nxt;
	logic wake_int_r, wake_int_nxt;
	logic rx_d_r, rx_d_nxt;
	logic [3:0] modem_d_r, modem_d_nxt;
	logic osc_en_r, osc_en_nxt;
	logic clk_en_r, clk_en_nxt;
	logic iso_r, iso_nxt;
	logic full_r, full_nxt;
	logic drv_oe_n_r, drv_oe_n_nxt;
	logic [3:0] code_r, code_nxt;
	logic modem_wake_r, modem_wake_nxt;
	logic pump_on, pump_ready;
	logic rx_start, modem_rise, modem_change, can_sleep, wake_req, tx_load;
	// line edge detection, inputs already synchronous
	assign rx_start = rx_in & !rx_d_r;
	assign modem_rise = |(modem_inputs & ~modem_d_r);
	assign modem_change = |(modem_inputs ^ modem_d_r);
	assign tx_load = thr_write & !iso_r;
	assign can_sleep = sleep_enable && !int_pending && (baud_divisor != 16'h0000)
		&& (modem_status_low == 4'h0) && !rx_in && !wake_int_r
		&& !modem_wake_r;
	assign wake_req = rx_start | tx_load | (|modem_status_low);
	assign wif.rx_start = rx_start;
	assign wif.tx_load = tx_load;
	assign wif.modem_rise = modem_rise;
	assign wif.core_asleep = (state_r == USPM_ASLEEP);
	assign wif.autosleep = charge_pump_autosleep;
	uspm_pump_ctrl #(
		.IDLE_LIMIT(IDLE_LIMIT)
	) u_pump (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ev(wif.pump),
		.tx_active(tx_active),
		.modem_any_high(|modem_inputs),
		.modem_change(modem_change),
		.pump_on(pump_on),
		.pump_ready(pump_ready)
	);
	// core sleep sequence
	always_comb begin
		state_nxt = state_r;
		wake_int_nxt = wake_int_r;
		osc_en_nxt = osc_en_r;
		clk_en_nxt = clk_en_r;
		unique case (state_r)
			USPM_AWAKE: begin
				if (can_sleep) begin
					state_nxt = USPM_ASLEEP;
					osc_en_nxt = 1'b0;
					clk_en_nxt = 1'b0;
				end
			end
			USPM_ASLEEP: begin
				if (wake_req || !sleep_enable) begin
					state_nxt = USPM_WAKING;
					osc_en_nxt = 1'b1;
				end
			end
			USPM_WAKING: begin
				if (osc_stable) begin
					state_nxt = USPM_AWAKE;
					clk_en_nxt = 1'b1;
					wake_int_nxt = sleep_enable;
				end
			end
		endcase
		// read clears, set wins over clear
		if (isr_read && !(state_r == USPM_WAKING && osc_stable && sleep_enable)) begin
			wake_int_nxt = 1'b0;
		end
	end
	// isolation, full sleep and driver state
	always_comb begin
		iso_nxt = bus_isolation_select && sleep_enable && (state_nxt == USPM_ASLEEP);
		full_nxt = (state_nxt == USPM_ASLEEP) && charge_pump_autosleep;
		drv_oe_n_nxt = !pump_ready;
		code_nxt = WAKE_ISR_CODE;
		rx_d_nxt = rx_in;
		modem_d_nxt = modem_inputs;
		// modem wake needs status read
		// the flag blocks re-sleep until the host has read modem status; a new wake wins over the read
		modem_wake_nxt = modem_wake_r;
		if (msr_read) begin
			modem_wake_nxt = 1'b0;
		end
		if ((state_r == USPM_ASLEEP) && (|modem_status_low)) begin
			modem_wake_nxt = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_r <= USPM_AWAKE;
			wake_int_r <= 1'b0;
			osc_en_r <= RST_OSC_EN;
			clk_en_r <= 1'b1;
			iso_r <= 1'b0;
			full_r <= 1'b0;
			drv_oe_n_r <= 1'b0;
			code_r <= WAKE_ISR_CODE;
			rx_d_r <= 1'b0;
			modem_d_r <= 4'h0;
			modem_wake_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			wake_int_r <= wake_int_nxt;
			osc_en_r <= osc_en_nxt;
			clk_en_r <= clk_en_nxt;
			iso_r <= iso_nxt;
			full_r <= full_nxt;
			drv_oe_n_r <= drv_oe_n_nxt;
			code_r <= code_nxt;
			rx_d_r <= rx_d_nxt;
			modem_d_r <= modem_d_nxt;
			modem_wake_r <= modem_wake_nxt;
		end
	end
	// outputs straight from their flops
	assign osc_enable = osc_en_r;
	assign core_clk_enable = clk_en_r;
	assign osc_out_enable = osc_en_r;
	assign pump_enable = pump_on;
	assign driver_oe_n = drv_oe_n_r;
	assign bus_isolate = iso_r;
	assign full_sleep = full_r;
	assign wake_int = wake_int_r;
	assign wake_isr_code = code_r;
endmodule
`default_nettype wire

// ### test/uspm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uspm_host_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// interrupt seen by the host
	input wire logic wake_int,
	// bus read pulses
	output logic isr_read,
	output logic msr_read
);
	logic read_nxt;
	// one read per interrupt; the gap keeps a second read off a fresh wake
	always_comb begin
		read_nxt = rst_b && wake_int && !isr_read;
	end
	always_ff @(posedge core_clk) begin
		isr_read <= read_nxt;
		msr_read <= read_nxt;
	end
endmodule
`default_nettype wire

// ### test/uspm_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uspm_top_properties #(
	parameter longint IDLE_LIMIT = uspm_pkg::IDLE_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// inputs
	input wire logic sleep_enable,
	input wire logic [15:0] baud_divisor,
	input wire logic charge_pump_autosleep,
	input wire logic int_pending,
	input wire logic [3:0] modem_status_low,
	input wire logic rx_in,
	input wire logic osc_stable,
	input wire logic thr_write,
	input wire logic isr_read,
	// outputs
	input wire logic osc_enable,
	input wire logic core_clk_enable,
	input wire logic pump_enable,
	input wire logic driver_oe_n,
	input wire logic full_sleep,
	input wire logic bus_isolate,
	input wire logic wake_int
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// awake with every sleep condition met but the modem status read
	sequence s_may_sleep;
		osc_enable && core_clk_enable && sleep_enable && !int_pending && baud_divisor != 16'h0000
			&& modem_status_low == 4'h0 && !rx_in && !wake_int && !thr_write;
	endsequence
	// oscillator back and settled, clock still gated
	sequence s_clock_ready;
		!core_clk_enable && osc_enable && osc_stable && sleep_enable;
	endsequence
	a_sleep_entry: assert property (s_may_sleep |=> !osc_enable) else $error("sleep not entered");
	a_pending_blocks: assert property (int_pending && osc_enable |=> osc_enable) else $error("slept while pending");
	a_rx_wakes: assert property (!osc_enable && $rose(rx_in) |-> ##[1:2] osc_enable) else $error("no rx wake");
	a_wake_release: assert property (s_clock_ready |=> core_clk_enable && wake_int) else $error("no wake release");
	a_clock_gated: assert property ($rose(core_clk_enable) |-> $past(osc_stable)) else $error("clock before stable");
	a_read_clears: assert property (wake_int && isr_read && core_clk_enable |=> !wake_int) else $error("read kept it");
	a_full_asleep: assert property (full_sleep |-> !osc_enable) else $error("full sleep while awake");
	a_drivers_off: assert property (!pump_enable ##1 !pump_enable |-> driver_oe_n) else $error("drivers on, pump off");
	a_iso_asleep: assert property (bus_isolate |-> !osc_enable) else $error("isolated while awake");
	a_pump_held: assert property (!charge_pump_autosleep && pump_enable |=> pump_enable) else $error("pump dropped");
endmodule
bind uspm_top uspm_top_properties #(.IDLE_LIMIT(IDLE_LIMIT)) i_uspm_top_properties (.*);
`default_nettype wire

// ### test/uspm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module uspm_top_tb;
	import uspm_pkg::*;
	// idle limit above the pump restart so a restart is never cut short
	localparam int IDLE = 3000;
	int failures = 0, total_checks = 0;
	logic core_clk = 1'h0, rst_b = 1'h0, sleep_enable = 1'h0, charge_pump_autosleep = 1'h0;
	logic bus_isolation_select = 1'h0, int_pending = 1'h0, rx_in = 1'h0, tx_active = 1'h0;
	logic osc_stable = 1'h0, thr_write = 1'h0, isr_read, msr_read;
	logic [15:0] baud_divisor = 16'h0000;
	logic [3:0] modem_status_low = 4'h0, modem_inputs = 4'h0, wake_isr_code;
	logic osc_enable, core_clk_enable, osc_out_enable, pump_enable, driver_oe_n, bus_isolate, full_sleep, wake_int;
	uspm_top #(.IDLE_LIMIT(IDLE)) i_uspm_top (.*);
	uspm_host_model i_uspm_host_model (.*);
	// 20 ns clock; oscillator settles one cycle after enable
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) osc_stable <= osc_enable;
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// bounded wait for the wake interrupt
	task automatic wait_wake;
		for (int i = 0; i < 20 && wake_int !== 1'h1; i++) step(1);
		`CHK("wake_int", 1'h1, wake_int)
		if (wake_int !== 1'h1) tally_and_finish();
	endtask
	initial begin
		step(20);
		rst_b = 1'h1;
		`CHK("wake_isr_code", WAKE_ISR_CODE, wake_isr_code)
		sleep_enable = 1'h1;
		int_pending = 1'h1;
		baud_divisor = 16'h000C;
		step(3);
		`CHK("osc_enable", 1'h1, osc_enable)
		int_pending = 1'h0;
		baud_divisor = 16'h0000;
		step(3);
		`CHK("osc_enable", 1'h1, osc_enable)
		baud_divisor = 16'h000C;
		step(3);
		`CHK("osc_out_enable", 1'h0, osc_out_enable)
		thr_write = 1'h1;
		step(1);
		thr_write = 1'h0;
		wait_wake();
		step(6);
		`CHK("osc_enable", 1'h0, osc_enable)
		modem_status_low = 4'h2;
		step(1);
		wait_wake();
		step(4);
		`CHK("osc_enable", 1'h1, osc_enable)
		$display("test sleep and wake done");
		bus_isolation_select = 1'h1;
		modem_status_low = 4'h0;
		step(3);
		`CHK("bus_isolate", 1'h1, bus_isolate)
		thr_write = 1'h1;
		step(1);
		thr_write = 1'h0;
		step(2);
		`CHK("osc_enable", 1'h0, osc_enable)
		rx_in = 1'h1;
		step(1);
		rx_in = 1'h0;
		wait_wake();
		`CHK("core_clk_enable", 1'h1, core_clk_enable)
		step(6);
		`CHK("wake_int", 1'h0, wake_int)
		`CHK("bus_isolate", 1'h1, bus_isolate)
		sleep_enable = 1'h0;
		step(4);
		`CHK("osc_enable", 1'h1, osc_enable)
		`CHK("wake_int", 1'h0, wake_int)
		$display("test power-save done");
		charge_pump_autosleep = 1'h1;
		tx_active = 1'h1;
		step(IDLE + 5);
		`CHK("pump_enable", 1'h1, pump_enable)
		tx_active = 1'h0;
		step(IDLE + 5);
		`CHK("pump_enable", 1'h0, pump_enable)
		`CHK("driver_oe_n", 1'h1, driver_oe_n)
		thr_write = 1'h1;
		step(1);
		thr_write = 1'h0;
		step(100);
		`CHK("pump_enable", 1'h1, pump_enable)
		`CHK("driver_oe_n", 1'h1, driver_oe_n)
		step(PUMP_UP_CYCLES - 101);
		`CHK("driver_oe_n", 1'h1, driver_oe_n)
		step(1);
		`CHK("driver_oe_n", 1'h0, driver_oe_n)
		sleep_enable = 1'h1;
		bus_isolation_select = 1'h0;
		step(3);
		`CHK("full_sleep", 1'h1, full_sleep)
		`CHK("pump_enable", 1'h0, pump_enable)
		charge_pump_autosleep = 1'h0;
		step(PUMP_UP_CYCLES + 5);
		`CHK("full_sleep", 1'h0, full_sleep)
		`CHK("osc_enable", 1'h0, osc_enable)
		`CHK("driver_oe_n", 1'h0, driver_oe_n)
		charge_pump_autosleep = 1'h1;
		step(2);
		`CHK("pump_enable", 1'h0, pump_enable)
		modem_status_low = 4'h1;
		wait_wake();
		`CHK("pump_enable", 1'h1, pump_enable)
		$display("test charge pump done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
